/* dv/dihp_line_model.sv */
`timescale 1ns/100ps
module dihp_line_model
  import dihp_pkg::*;
(
  input wire logic off_hook,
  input wire logic ring_pos_on,
  input wire logic ring_neg_on,
  input wire logic lock_on,
  input wire logic power_on,
  input wire logic [LC_W-1:0] cur,
  output dihp_line_t line_in
);
  // -----------------------------------------------------------------
  // line side levels, asynchronous to the core clock
  // -----------------------------------------------------------------
  // no loop current flows while on-hook, so an overload needs off_hook
  assign line_in = '{ring_pos: ring_pos_on, ring_neg: ring_neg_on,
                     frame_lock: lock_on, power_ok: power_on,
                     loop_current: off_hook ? cur : 5'h00};
endmodule : dihp_line_model

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import dihp_pkg::*;
  localparam int HOLD = 20;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq, off_hook, line_monitor_enable, line_side_powerdown, logic_powerdown;
  logic ring_pos_on = 1'b0;
  logic ring_neg_on = 1'b0;
  logic lock_on = 1'b1;
  logic power_on = 1'b1;
  logic [4:0] cur = 5'h00;
  dihp_line_t line_in;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] bitv [4] = '{8'h80, 8'h20, 8'h08, 8'h04};

  always #20 core_clk = ~core_clk;

  dihp_line_model line (.off_hook(off_hook), .ring_pos_on(ring_pos_on),
    .ring_neg_on(ring_neg_on), .lock_on(lock_on), .power_on(power_on), .cur(cur),
    .line_in(line_in));

  dihp_regs #(.RING_HOLD(HOLD)) dut (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_in(line_in), .irq(irq), .off_hook(off_hook),
    .line_monitor_enable(line_monitor_enable),
    .line_side_powerdown(line_side_powerdown), .logic_powerdown(logic_powerdown));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %02h seen %02h", what, exp, got);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("reg_%02h", a), reg_rdata, e);
    @(posedge core_clk);
  endtask : rd_chk

  task wait_irq(input logic v);
    int i;
    for (i = 0; i < 12; i++) begin
      @(negedge core_clk);
      if (irq === v) break;
    end
    chk("irq", {7'h00, irq}, {7'h00, v});
    if (irq !== v) report_and_stop();
    else @(posedge core_clk);
  endtask : wait_irq

  task do_reset;
    rstn <= 1'b0;
    cyc(16);
    rstn <= 1'b1;
    cyc(1);
  endtask : do_reset

  task set_ev(input int k, input logic on);
    case (k)
      0: ring_pos_on <= on;
      1: lock_on <= ~on;
      2: power_on <= ~on;
      default: begin
        if (on) wr(8'h05, 8'h01);
        cur <= on ? 5'h1F : 5'h00;
        if (!on) wr(8'h05, 8'h00);
      end
    endcase
  endtask : set_ev

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_reset;
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h06, 8'h10);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    chk("pdl", {7'h00, line_side_powerdown}, 8'h01);
    chk("pdn", {7'h00, logic_powerdown}, 8'h00);
  endtask : t_reset

  // one event kind with its mask on or off; mask off also uses the clear register
  task t_event(input int k, input logic m);
    wr(8'h03, m ? bitv[k] : 8'h00);
    rd_chk(8'h03, m ? bitv[k] : 8'h00);
    set_ev(k, 1'b1);
    if (m) wait_irq(1'b1);
    else begin
      cyc(10);
      chk("irq", {7'h00, irq}, 8'h00);
    end
    rd_chk(8'h04, bitv[k]);
    set_ev(k, 1'b0);
    cyc(4);
    wr(8'h04, bitv[k]);
    rd_chk(8'h04, k == 2 ? 8'h00 : bitv[k]);
    if (m) wr(8'h04, 8'h00);
    else wr(8'h10, bitv[k]);
    rd_chk(8'h04, 8'h00);
    wait_irq(1'b0);
    cyc(HOLD + 10);
  endtask : t_event

  task t_ring;
    wr(8'h03, 8'h00);
    ring_neg_on <= 1'b1;
    cyc(4);
    rd_chk(8'h05, 8'h44);
    ring_neg_on <= 1'b0;
    ring_pos_on <= 1'b1;
    cyc(4);
    rd_chk(8'h05, 8'h24);
    ring_pos_on <= 1'b0;
    cyc(4);
    rd_chk(8'h05, 8'h04);
    cyc(HOLD + 4);
    rd_chk(8'h05, 8'h00);
    ring_pos_on <= 1'b1;
    cyc(4);
    ring_pos_on <= 1'b0;
    cyc(4);
    wr(8'h05, 8'h01);
    cyc(2);
    rd_chk(8'h05, 8'h01);
    chk("hook", {7'h00, off_hook}, 8'h01);
    wr(8'h05, 8'h6D);
    rd_chk(8'h05, 8'h09);
    chk("mon", {7'h00, line_monitor_enable}, 8'h01);
    wr(8'h05, 8'h00);
    cyc(1);
    chk("mon", {7'h00, line_monitor_enable}, 8'h00);
    chk("hook", {7'h00, off_hook}, 8'h00);
    wr(8'h04, 8'h00);
  endtask : t_ring

  task t_power;
    wr(8'h06, 8'h00);
    cyc(1);
    chk("pdl", {7'h00, line_side_powerdown}, 8'h00);
    rd_chk(8'h06, 8'h00);
    wr(8'h06, 8'h08);
    wr(8'h06, 8'h00);
    rd_chk(8'h06, 8'h08);
    chk("pdn", {7'h00, logic_powerdown}, 8'h01);
    do_reset();
    chk("pdn", {7'h00, logic_powerdown}, 8'h00);
    chk("pdl", {7'h00, line_side_powerdown}, 8'h01);
  endtask : t_power

  // -----------------------------------------------------------------
  // sequence and hang guard
  // -----------------------------------------------------------------
  initial begin
    do_reset();
    t_reset();
    for (int k = 0; k < 4; k++) begin
      t_event(k, 1'b1);
      t_event(k, 1'b0);
    end
    t_ring();
    t_power();
    report_and_stop();
  end

  initial begin
    cyc(20000);
    fail_count++;
    report_and_stop();
  end
endmodule : tb_top

/* hdl/dihp_pkg.sv */
package dihp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h03;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h04;
  localparam logic [7:0] OFS_LINE_CTRL = 8'h05;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h06;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam int BIT_RING = 7;
  localparam int BIT_FRAME = 5;
  localparam int BIT_DROP = 3;
  localparam int BIT_OVL = 2;
  localparam int BIT_NEG = 6;
  localparam int BIT_POS = 5;
  localparam int BIT_MON = 3;
  localparam int BIT_RDT = 2;
  localparam int BIT_HOOK = 0;
  localparam int BIT_PDL = 4;
  localparam int BIT_PDN = 3;
  localparam logic [7:0] IRQ_FIELDS = 8'hAC;
  localparam logic [7:0] STICKY_FIELDS = 8'hA4;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic RST_HOOK = 1'h0;
  localparam logic RST_MON = 1'h0;
  localparam logic RST_PDL = 1'h1;
  localparam logic RST_PDN = 1'h0;
  localparam int LC_W = 5;
  localparam logic [LC_W-1:0] LC_MAX = 5'h1F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int RING_HOLD_S = 5;
  localparam int RING_HOLD_CYC = RING_HOLD_S * CLK_HZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ring_pos;
    logic ring_neg;
    logic frame_lock;
    logic power_ok;
    logic [LC_W-1:0] loop_current;
  } dihp_line_t;

  typedef enum logic [1:0] {
    RT_IDLE = 2'h0,
    RT_RING = 2'h1,
    RT_HOLD = 2'h3
  } dihp_ring_st_t;
endpackage : dihp_pkg

/* hdl/dihp_regs.sv */
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module dihp_regs
  import dihp_pkg::*;
#(
  parameter int RING_HOLD = RING_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire dihp_line_t line_in,
  output logic irq,
  output logic off_hook,
  output logic line_monitor_enable,
  output logic line_side_powerdown,
  output logic logic_powerdown
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dihp_line_t line_s;
  logic ring_active;
  logic ring_q_ff;
  logic lock_q_ff;
  logic [LC_W-1:0] lc_q_ff;
  logic lc_full;
  logic [DATA_W-1:0] mask_ff;
  logic [DATA_W-1:0] flags_ff;
  logic [DATA_W-1:0] nxt_flags;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rdata_ff;
  logic hook_ff;
  logic mon_ff;
  logic pdl_ff;
  logic pdn_ff;
  logic irq_ff;
  logic wr_mask;
  logic wr_flags;
  logic wr_line;
  logic wr_pwr;
  logic wr_clear;

  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // line inputs and ring timing
  // ----------------------------------------------------------------
  // all line indications are asynchronous to core_clk
  dihp_sync #(
    .W($bits(dihp_line_t))
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(line_in),
    .dout(line_s)
  );

  dihp_ring_timer #(
    .HOLD(RING_HOLD)
  ) u_ring (
    .core_clk(core_clk),
    .rstn(rstn),
    .ring_pos(line_s.ring_pos),
    .ring_neg(line_s.ring_neg),
    .off_hook(hook_ff),
    .ring_active(ring_active)
  );

  // history for edge events; lock history resets low so that
  // a link still training after reset is not reported as lost
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ring_q_ff <= 1'b0;
      lock_q_ff <= 1'b0;
      lc_q_ff <= '0;
    end else begin
      ring_q_ff <= ring_active;
      lock_q_ff <= line_s.frame_lock;
      lc_q_ff <= line_s.loop_current;
    end
  end

  // loop current crosses as five loose bits, so a skewed sample in
  // mid-change can look like all ones; two equal samples are required
  assign lc_full = (line_s.loop_current == LC_MAX) && (lc_q_ff == LC_MAX);

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_mask = reg_wr && reg_hit(reg_addr, OFS_IRQ_MASK);
  assign wr_flags = reg_wr && reg_hit(reg_addr, OFS_IRQ_FLAGS);
  assign wr_line = reg_wr && reg_hit(reg_addr, OFS_LINE_CTRL);
  assign wr_pwr = reg_wr && reg_hit(reg_addr, OFS_PWR_CTRL);
  assign wr_clear = reg_wr && reg_hit(reg_addr, OFS_IRQ_CLEAR);

  // ----------------------------------------------------------------
  // interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mask_ff <= RST_IRQ_MASK;
    end else if (wr_mask) begin
      mask_ff <= reg_wdata & IRQ_FIELDS;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  always_comb begin
    set_vec = '0;
    set_vec[BIT_RING] = ring_active & ~ring_q_ff;
    set_vec[BIT_FRAME] = lock_q_ff & ~line_s.frame_lock;
    set_vec[BIT_OVL] = lc_full;
  end

  // zero written to the flag register clears; the clear register
  // offers a write-one path so drivers need no read-modify-write
  always_comb begin
    clr_vec = '0;
    if (wr_flags) begin
      clr_vec = ~reg_wdata & STICKY_FIELDS;
    end
    if (wr_clear) begin
      clr_vec = clr_vec | (reg_wdata & STICKY_FIELDS);
    end
  end

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & STICKY_FIELDS;
    nxt_flags[BIT_DROP] = ~line_s.power_ok;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flags_ff <= RST_IRQ_FLAGS;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // one cycle of latency from flag to pin keeps irq glitch free
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(flags_ff & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // hook and monitor control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hook_ff <= RST_HOOK;
      mon_ff <= RST_MON;
    end else if (wr_line) begin
      hook_ff <= reg_wdata[BIT_HOOK];
      mon_ff <= reg_wdata[BIT_MON];
    end
  end

  // ----------------------------------------------------------------
  // power control
  // ----------------------------------------------------------------
  // logic powerdown latches; writing zero cannot wake the logic,
  // only the reset does
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pdl_ff <= RST_PDL;
      pdn_ff <= RST_PDN;
    end else if (wr_pwr) begin
      pdl_ff <= reg_wdata[BIT_PDL];
      pdn_ff <= pdn_ff | reg_wdata[BIT_PDN];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    unique case (reg_addr)
      OFS_IRQ_MASK: rd_word = mask_ff;
      OFS_IRQ_FLAGS: rd_word = flags_ff;
      OFS_LINE_CTRL: begin
        rd_word[BIT_NEG] = line_s.ring_neg;
        rd_word[BIT_POS] = line_s.ring_pos;
        rd_word[BIT_MON] = mon_ff;
        rd_word[BIT_RDT] = ring_active;
        rd_word[BIT_HOOK] = hook_ff;
      end
      OFS_PWR_CTRL: begin
        rd_word[BIT_PDL] = pdl_ff;
        rd_word[BIT_PDN] = pdn_ff;
      end
      default: rd_word = '0;
    endcase
  end

  // data are valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= rd_word;
    end else begin
      rdata_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign off_hook = hook_ff;
  assign line_monitor_enable = mon_ff;
  assign line_side_powerdown = pdl_ff;
  assign logic_powerdown = pdn_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_RING_IRQ: assert property (
    flags_ff[BIT_RING] && mask_ff[BIT_RING] |=> irq_ff
  ) else $error("ring flag enabled but no interrupt");

  AST_FRAME_IRQ: assert property (
    flags_ff[BIT_FRAME] && mask_ff[BIT_FRAME] |=> irq_ff
  ) else $error("frame flag enabled but no interrupt");

  AST_DROP_IRQ: assert property (
    flags_ff[BIT_DROP] && mask_ff[BIT_DROP] |=> irq_ff
  ) else $error("dropout flag enabled but no interrupt");

  AST_OVL_IRQ: assert property (
    flags_ff[BIT_OVL] && mask_ff[BIT_OVL] |=> irq_ff
  ) else $error("overload flag enabled but no interrupt");

  AST_NO_IRQ: assert property (
    !(|(flags_ff & mask_ff)) |=> !irq_ff
  ) else $error("interrupt without enabled flag");

  AST_RING_STICKY: assert property (
    flags_ff[BIT_RING]
    && !(wr_flags && !reg_wdata[BIT_RING])
    && !(wr_clear && reg_wdata[BIT_RING])
    |=> flags_ff[BIT_RING]
  ) else $error("ring flag lost without clear");

  AST_RING_SET: assert property (
    $rose(ring_active) |=> flags_ff[BIT_RING]
  ) else $error("ring start did not set flag");

  AST_FRAME_SET: assert property (
    $fell(line_s.frame_lock) |=> flags_ff[BIT_FRAME]
  ) else $error("frame loss did not set flag");

  AST_FRAME_NO_SET: assert property (
    !flags_ff[BIT_FRAME] && !$fell(line_s.frame_lock) |=> !flags_ff[BIT_FRAME]
  ) else $error("frame flag set without lock loss");

  AST_RING_NO_SET: assert property (
    !flags_ff[BIT_RING] && !$rose(ring_active) |=> !flags_ff[BIT_RING]
  ) else $error("ring flag set without ring start");

  AST_DROP_LEVEL: assert property (
    1'b1 |=> flags_ff[BIT_DROP] != $past(line_s.power_ok)
  ) else $error("dropout flag does not track power");

  AST_OVL_SET: assert property (
    line_s.loop_current == LC_MAX && $past(line_s.loop_current) == LC_MAX
    |=> flags_ff[BIT_OVL]
  ) else $error("overload not flagged");

  AST_OVL_ONE_SAMPLE: assert property (
    line_s.loop_current == LC_MAX && $past(line_s.loop_current) != LC_MAX
    && !flags_ff[BIT_OVL] |=> !flags_ff[BIT_OVL]
  ) else $error("single all-ones sample set overload flag");

  AST_NEG_READ: assert property (
    reg_rd && reg_addr == OFS_LINE_CTRL
    |=> reg_rdata[BIT_NEG] == $past(line_s.ring_neg)
  ) else $error("negative ring indication wrong");

  AST_POS_READ: assert property (
    reg_rd && reg_addr == OFS_LINE_CTRL
    |=> reg_rdata[BIT_POS] == $past(line_s.ring_pos)
  ) else $error("positive ring indication wrong");

  AST_MON_WRITE: assert property (
    wr_line |=> line_monitor_enable == $past(reg_wdata[BIT_MON])
  ) else $error("monitor mode not taken");

  AST_RING_OFFHOOK: assert property (
    hook_ff |=> !ring_active
  ) else $error("ring indication held while off-hook");

  AST_HOOK_WRITE: assert property (
    wr_line |=> off_hook == $past(reg_wdata[BIT_HOOK])
  ) else $error("hook command not taken");

  AST_PDL_WRITE: assert property (
    wr_pwr |=> line_side_powerdown == $past(reg_wdata[BIT_PDL])
  ) else $error("line-side powerdown not taken");

  AST_PDN_HOLD: assert property (
    logic_powerdown |=> logic_powerdown [*2]
  ) else $error("logic powerdown released without reset");

  AST_ONE_KEEPS: assert property (
    wr_flags && reg_wdata[BIT_OVL] && flags_ff[BIT_OVL]
    && !wr_clear |=> flags_ff[BIT_OVL]
  ) else $error("writing one cleared overload flag");

  COV_RING_IRQ: cover property (
    $rose(ring_active) ##1 flags_ff[BIT_RING] ##1 irq_ff
  );

  COV_OVL_CLEAR: cover property (
    flags_ff[BIT_OVL] ##1 wr_flags ##1 !flags_ff[BIT_OVL]
  );

  COV_PDN: cover property (
    wr_pwr && reg_wdata[BIT_PDN] ##1 logic_powerdown
  );

  COV_RING_TIMEOUT: cover property (
    ring_active ##1 !ring_active && !hook_ff
  );

endmodule : dihp_regs

/* hdl/dihp_ring_timer.sv */
`timescale 1ns/100ps
module dihp_ring_timer
  import dihp_pkg::*;
#(
  parameter int HOLD = RING_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ring_pos,
  input wire logic ring_neg,
  input wire logic off_hook,
  output logic ring_active
);
  localparam int CW = $clog2(HOLD + 1);
  dihp_ring_st_t st_ff;
  dihp_ring_st_t nxt_st;
  logic [CW-1:0] cnt_ff;
  logic active_ff;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      RT_IDLE: if (!off_hook && (ring_pos || ring_neg)) nxt_st = RT_RING;
      RT_RING: if (off_hook) nxt_st = RT_IDLE;
               else if (!ring_pos) nxt_st = RT_HOLD;
      // only a positive ring restarts the hold window
      RT_HOLD: if (off_hook) nxt_st = RT_IDLE;
               else if (ring_pos) nxt_st = RT_RING;
               else if (cnt_ff == '0) nxt_st = RT_IDLE;
      default: nxt_st = RT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) st_ff <= RT_IDLE;
    else st_ff <= nxt_st;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) cnt_ff <= '0;
    else if (nxt_st != RT_HOLD) cnt_ff <= CW'(HOLD - 1);
    else if (cnt_ff != '0) cnt_ff <= cnt_ff - 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) active_ff <= 1'b0;
    else active_ff <= (nxt_st != RT_IDLE);
  end

  assign ring_active = active_ff;
endmodule : dihp_ring_timer

/* hdl/dihp_sync.sv */
`timescale 1ns/100ps
module dihp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] safe_ff;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      safe_ff <= '0;
    end else begin
      meta_ff <= din;
      safe_ff <= meta_ff;
    end
  end

  assign dout = safe_ff;
endmodule : dihp_sync
